// File: hw/timer_pwm_lowpower_irq.sv
// 16-bit free-running timer with two-compare PWM, captures, flags and halt handling.
// Assumes software strobes come from clk_sys_in logic; capture pins are asynchronous.
//
// What this block does
// - PWM frequency and pulse set by compares
// - PWM takes compare one and second register
// - Compare values double-buffered, loaded at period end in PWM, every cycle otherwise
// - Pin takes level one or two on match
// - Levels 1/0 give pulse = second minus first
// - Equal levels give a constant pin level
// - Second match reloads counter to FFFC
// - Match lands at elapsed counts minus five
// - High byte write inhibits compare until low
// - No compare flags set during PWM
// - Second match sets first capture flag in PWM
// - PWM disconnects capture one, keeps capture two
// - PWM plus single pulse means PWM only
// - Pin carries waveform only when enabled
// - Wait has no effect; enabled events wake
// - Halt freezes counter; resumes or resets after
// - Flags gated by their matching enables
// - One interrupt, needs enable and clear mask
// - Three control groups, six data pairs
// - Clock field picks divider or external clock
`include "timer_pwm_map.svh"
`default_nettype none

module timer_pwm_lowpower_irq #(
	parameter int CNT_W = 16
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	// Control bits
	input  wire logic             pwm_mode_in,
	input  wire logic             single_pulse_select_in,
	input  wire logic             match_level_first_in,
	input  wire logic             match_level_second_in,
	input  wire logic             compare_pin_enable_first_in,
	input  wire logic [1:0]       clock_select_field_in,
	input  wire logic             capture_edge_first_in,
	input  wire logic             capture_edge_second_in,
	input  wire logic             ext_edge_in,
	input  wire logic             capture_irq_enable_in,
	input  wire logic             compare_irq_enable_in,
	input  wire logic             overflow_irq_enable_in,
	input  wire logic             cpu_irq_mask_in,
	input  wire logic             halt_in,
	// Compare byte writes and register accesses
	input  wire logic             compare_high_byte_wr_in,
	input  wire logic             compare_low_byte_wr_in,
	input  wire logic             compare_sel_in,
	input  wire logic [7:0]       wr_data_in,
	input  wire logic [1:0]       compare_low_byte_rd_in,
	input  wire logic [1:0]       capture_low_byte_acc_in,
	input  wire logic             counter_low_byte_acc_in,
	input  wire logic             status_rd_in,
	// Pins
	input  wire logic             capture_pin_first_in,
	input  wire logic             capture_pin_second_in,
	input  wire logic             ext_clk_in,
	output logic                  compare_output_pin_first_out,
	output logic                  compare_output_pin_first_oe_out,
	// State
	output logic [CNT_W-1:0]      counter_out,
	output logic [CNT_W-1:0]      alt_counter_out,
	output logic [CNT_W-1:0]      compare_value_first_out,
	output logic [CNT_W-1:0]      compare_value_second_out,
	output logic [CNT_W-1:0]      capture_value_first_out,
	output logic [CNT_W-1:0]      capture_value_second_out,
	output logic                  capture_flag_first_out,
	output logic                  capture_flag_second_out,
	output logic                  compare_flag_first_out,
	output logic                  compare_flag_second_out,
	output logic                  overflow_flag_out,
	output logic                  timer_irq_out,
	output logic                  wait_wake_out
);
	if (CNT_W != 16) begin : g_width_check
		$error("timer_pwm_lowpower_irq supports only a 16-bit counter");
	end

	localparam int NF = `TMR_NUM_FLAGS;

	timer_pwm_pkg::mode_t mode;
	logic [CNT_W-1:0]     cnt_q;
	logic [CNT_W-1:0]     shadow_q [2];
	logic [CNT_W-1:0]     active_q [2];
	logic [CNT_W-1:0]     cap_q [2];
	logic [1:0]           hi_pend_q;
	logic [1:0]           cap_meta_q;
	logic [1:0]           cap_sync_q;
	logic [1:0]           cap_prev_q;
	logic [1:0]           cap_edge;
	logic [1:0]           cap_live;
	logic [1:0]           armed_q;
	logic                 halt_prev_q;
	logic                 halt_exit;
	logic                 tick;
	logic                 tick_q;
	logic [1:0]           match;
	logic                 reload;
	logic                 wrap;
	logic                 pin_q;
	logic [NF-1:0]        flag_q;
	logic [NF-1:0]        seen_q;
	logic [NF-1:0]        flag_set;
	logic [NF-1:0]        flag_clr;
	logic [NF-1:0]        flag_en;
	logic [1:0]           cmp_lo_wr;
	logic [1:0]           cmp_hi_wr;

	// Replace one byte of a 16-bit value
	function automatic logic [CNT_W-1:0] put_byte(input logic [CNT_W-1:0] v,
		input logic hi, input logic [7:0] b);
		logic [CNT_W-1:0] r;
		r = v;
		if (hi) begin
			r[15:8] = b;
		end else begin
			r[7:0] = b;
		end
		return r;
	endfunction

	always_comb begin
		if (pwm_mode_in) begin
			mode = timer_pwm_pkg::MODE_PWM;
		end else if (single_pulse_select_in) begin
			mode = timer_pwm_pkg::MODE_SINGLE;
		end else begin
			mode = timer_pwm_pkg::MODE_COMPARE;
		end
	end

	// Count enable; halt stops the divider and the counter alike
	timer_tick_gen u_tick (
		.clk_sys_in            (clk_sys_in),
		.rst_in                (rst_in),
		.enable_in             (!halt_in),
		.clock_select_field_in (clock_select_field_in),
		.ext_edge_in           (ext_edge_in),
		.ext_clk_in            (ext_clk_in),
		.tick_out              (tick)
	);

	// Capture pins: two-stage synchroniser, then edge detect
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cap_meta_q <= 2'h0;
			cap_sync_q <= 2'h0;
			cap_prev_q <= 2'h0;
		end else begin
			cap_meta_q <= {capture_pin_second_in, capture_pin_first_in};
			cap_sync_q <= cap_meta_q;
			cap_prev_q <= cap_sync_q;
		end
	end

	always_comb begin
		cap_edge[0] = (cap_sync_q[0] != cap_prev_q[0]) && (cap_sync_q[0] == capture_edge_first_in);
		cap_edge[1] = (cap_sync_q[1] != cap_prev_q[1]) &&
			(cap_sync_q[1] == capture_edge_second_in);
		cap_live[0] = cap_edge[0] && (mode == timer_pwm_pkg::MODE_COMPARE);
		cap_live[1] = cap_edge[1];
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			halt_prev_q <= 1'b0;
		end else begin
			halt_prev_q <= halt_in;
		end
	end

	// Reset wake-up is handled by rst_in itself; this is the interrupt wake-up
	assign halt_exit = halt_prev_q && !halt_in;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			armed_q <= 2'h0;
		end else if (halt_exit) begin
			armed_q <= 2'h0;
		end else if (halt_in) begin
			armed_q <= armed_q | cap_live;
		end
	end

	// Compare registers: byte writes into the shadow, inhibit while high byte pends
	assign cmp_hi_wr = compare_high_byte_wr_in ? (compare_sel_in ? 2'h2 : 2'h1) : 2'h0;
	assign cmp_lo_wr = compare_low_byte_wr_in ? (compare_sel_in ? 2'h2 : 2'h1) : 2'h0;

	// One process for both channels keeps a single driver per register
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 2; i++) begin
			if (rst_in) begin
				shadow_q[i]  <= `TMR_CMP_RESET;
				hi_pend_q[i] <= 1'b0;
			end else if (cmp_hi_wr[i]) begin
				shadow_q[i]  <= put_byte(shadow_q[i], 1'b1, wr_data_in);
				hi_pend_q[i] <= 1'b1;
			end else if (cmp_lo_wr[i]) begin
				shadow_q[i]  <= put_byte(shadow_q[i], 1'b0, wr_data_in);
				hi_pend_q[i] <= 1'b0;
			end
		end
	end

	// PWM loads the working value only at the period end
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < 2; i++) begin
			if (rst_in) begin
				active_q[i] <= `TMR_CMP_RESET;
			end else if (mode != timer_pwm_pkg::MODE_PWM) begin
				active_q[i] <= shadow_q[i];
			end else if (reload) begin
				active_q[i] <= shadow_q[i];
			end
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_cmp
		// One match per counter value, taken the cycle after the count lands
		assign match[i] = tick_q && !halt_in && !hi_pend_q[i] &&
			(cnt_q == active_q[i]);
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick;
		end
	end

	// Reload one tick after the second match, giving value + 5 ticks per period
	assign reload = tick && (mode == timer_pwm_pkg::MODE_PWM) && !hi_pend_q[1] &&
		(cnt_q == active_q[1]);
	assign wrap = tick && !reload && (cnt_q == `TMR_CNT_MAX);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt_q <= `TMR_CNT_RESET;
		end else if (reload) begin
			cnt_q <= `TMR_PWM_RELOAD;
		end else if (tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Compare output pin latch, low from reset
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			pin_q <= 1'b0;
		end else if (mode == timer_pwm_pkg::MODE_PWM) begin
			if (match[1]) begin
				pin_q <= match_level_second_in;
			end else if (match[0]) begin
				pin_q <= match_level_first_in;
			end
		end else if (mode == timer_pwm_pkg::MODE_COMPARE && match[0]) begin
			pin_q <= match_level_first_in;
		end
	end

	assign compare_output_pin_first_out    = pin_q;
	assign compare_output_pin_first_oe_out = compare_pin_enable_first_in;

	// Captures: live edges while running, armed edges at the halt exit
	for (genvar i = 0; i < 2; i++) begin : g_cap
		always_ff @(posedge clk_sys_in) begin
			if (rst_in) begin
				cap_q[i] <= `TMR_CAP_RESET;
			end else if ((cap_live[i] && !halt_in) || (halt_exit && armed_q[i])) begin
				cap_q[i] <= cnt_q;
			end
		end
	end

	always_comb begin
		flag_set = '0;
		flag_set[`TMR_FLAG_CAP1] = (cap_live[0] && !halt_in) || (halt_exit && armed_q[0]) ||
			((mode == timer_pwm_pkg::MODE_PWM) && match[1]);
		flag_set[`TMR_FLAG_CAP2] = (cap_live[1] && !halt_in) || (halt_exit && armed_q[1]);
		flag_set[`TMR_FLAG_CMP1] = (mode == timer_pwm_pkg::MODE_COMPARE) && match[0];
		flag_set[`TMR_FLAG_CMP2] = (mode != timer_pwm_pkg::MODE_PWM) && match[1];
		flag_set[`TMR_FLAG_OVF]  = wrap;
	end

	// Two-step clear: status read while set, then low-byte access
	always_comb begin
		flag_clr = '0;
		flag_clr[`TMR_FLAG_CAP1] = capture_low_byte_acc_in[0];
		flag_clr[`TMR_FLAG_CAP2] = capture_low_byte_acc_in[1];
		flag_clr[`TMR_FLAG_CMP1] = cmp_lo_wr[0] || compare_low_byte_rd_in[0];
		flag_clr[`TMR_FLAG_CMP2] = cmp_lo_wr[1] || compare_low_byte_rd_in[1];
		flag_clr[`TMR_FLAG_OVF]  = counter_low_byte_acc_in;
		flag_clr = flag_clr & seen_q;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			seen_q <= '0;
		end else if (status_rd_in) begin
			seen_q <= flag_q;
		end else begin
			seen_q <= seen_q & ~flag_clr;
		end
	end

	// A set in the clearing cycle wins
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			flag_q <= '0;
		end else begin
			flag_q <= (flag_q & ~flag_clr) | flag_set;
		end
	end

	always_comb begin
		flag_en = '0;
		flag_en[`TMR_FLAG_CAP1] = capture_irq_enable_in;
		flag_en[`TMR_FLAG_CAP2] = capture_irq_enable_in;
		flag_en[`TMR_FLAG_CMP1] = compare_irq_enable_in;
		flag_en[`TMR_FLAG_CMP2] = compare_irq_enable_in;
		flag_en[`TMR_FLAG_OVF]  = overflow_irq_enable_in;
	end

	// Single shared request; no wake source from halt
	assign timer_irq_out = (|(flag_q & flag_en)) && !cpu_irq_mask_in;
	assign wait_wake_out = timer_irq_out;

	// Data register pairs
	assign counter_out              = cnt_q;
	assign alt_counter_out          = cnt_q;
	assign compare_value_first_out  = shadow_q[0];
	assign compare_value_second_out = shadow_q[1];
	assign capture_value_first_out  = cap_q[0];
	assign capture_value_second_out = cap_q[1];
	assign capture_flag_first_out   = flag_q[`TMR_FLAG_CAP1];
	assign capture_flag_second_out  = flag_q[`TMR_FLAG_CAP2];
	assign compare_flag_first_out   = flag_q[`TMR_FLAG_CMP1];
	assign compare_flag_second_out  = flag_q[`TMR_FLAG_CMP2];
	assign overflow_flag_out        = flag_q[`TMR_FLAG_OVF];
endmodule

`default_nettype wire

// File: hw/timer_pwm_map.svh
// Constants of the 16-bit PWM timer: reset values, reloads, clock codes.
// Assumes inclusion by bare name from files under hw/.
`ifndef TIMER_PWM_MAP_SVH
`define TIMER_PWM_MAP_SVH

`define TMR_CNT_RESET      16'hFFFC
`define TMR_PWM_RELOAD     16'hFFFC
`define TMR_CNT_MAX        16'hFFFF
`define TMR_CMP_RESET      16'h8000
`define TMR_CAP_RESET      16'h0000
`define TMR_CLK_DIV4       2'h0
`define TMR_CLK_DIV2       2'h1
`define TMR_CLK_DIV8       2'h2
`define TMR_CLK_EXT        2'h3
`define TMR_FLAG_CAP1      3'h0
`define TMR_FLAG_CAP2      3'h1
`define TMR_FLAG_CMP1      3'h2
`define TMR_FLAG_CMP2      3'h3
`define TMR_FLAG_OVF       3'h4
`define TMR_NUM_FLAGS      5

`endif

// File: hw/timer_pwm_pkg.sv
// Types shared by the PWM timer files.
// Assumes compilation before every other hw/ file.
`default_nettype none

package timer_pwm_pkg;
	typedef enum logic [1:0] {
		MODE_COMPARE,
		MODE_SINGLE,
		MODE_PWM
	} mode_t;
endpackage

`default_nettype wire

// File: hw/timer_tick_gen.sv
// Timer count enable: CPU clock divided by 2, 4 or 8, or an external clock edge.
// Assumes ext_clk_in is an asynchronous pin; enable_in comes from clk_sys_in logic.
`include "timer_pwm_map.svh"
`default_nettype none

module timer_tick_gen (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	input  wire logic       enable_in,
	input  wire logic [1:0] clock_select_field_in,
	input  wire logic       ext_edge_in,
	input  wire logic       ext_clk_in,
	output logic            tick_out
);
	logic [2:0] div_q;
	logic       ext_meta_q;
	logic       ext_sync_q;
	logic       ext_prev_q;
	logic       ext_hit;

	// Free-running divider, frozen while counting is stopped
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			div_q <= 3'h0;
		end else if (enable_in) begin
			div_q <= div_q + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ext_meta_q <= 1'b0;
			ext_sync_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_meta_q <= ext_clk_in;
			ext_sync_q <= ext_meta_q;
			ext_prev_q <= ext_sync_q;
		end
	end

	assign ext_hit = (ext_sync_q != ext_prev_q) && (ext_sync_q == ext_edge_in);

	always_comb begin
		case (clock_select_field_in)
			`TMR_CLK_DIV4: tick_out = enable_in && (div_q[1:0] == 2'h3);
			`TMR_CLK_DIV2: tick_out = enable_in && div_q[0];
			`TMR_CLK_DIV8: tick_out = enable_in && (div_q == 3'h7);
			default:       tick_out = enable_in && ext_hit;
		endcase
	end
endmodule

`default_nettype wire

// File: bench/timer_pwm_lowpower_irq_asserts.sv
// Port-level checker for the PWM timer.
// Assumes binding onto timer_pwm_lowpower_irq and a synchronous high reset.
`default_nettype none

module timer_pwm_checker #(
	parameter int CNT_W = 16
) (
	input wire logic             clk_sys_in,
	input wire logic             rst_in,
	input wire logic             pwm_mode_in,
	input wire logic             match_level_first_in,
	input wire logic             match_level_second_in,
	input wire logic             compare_pin_enable_first_in,
	input wire logic             capture_irq_enable_in,
	input wire logic             compare_irq_enable_in,
	input wire logic             overflow_irq_enable_in,
	input wire logic             cpu_irq_mask_in,
	input wire logic             halt_in,
	input wire logic             compare_output_pin_first_out,
	input wire logic             compare_output_pin_first_oe_out,
	input wire logic [CNT_W-1:0] counter_out,
	input wire logic [CNT_W-1:0] compare_value_first_out,
	input wire logic             capture_flag_first_out,
	input wire logic             capture_flag_second_out,
	input wire logic             compare_flag_first_out,
	input wire logic             compare_flag_second_out,
	input wire logic             overflow_flag_out,
	input wire logic             timer_irq_out,
	input wire logic             wait_wake_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_halt_held;
		halt_in [*3];
	endsequence

	// Counter lands on the reload value by a reload, not by counting
	sequence s_reload;
		pwm_mode_in && $past(pwm_mode_in) && !$past(rst_in) && counter_out == 16'hFFFC
			&& $past(counter_out) != 16'hFFFC && $past(counter_out) != 16'hFFFB;
	endsequence

	chk_pin_enable_copy: assert property (
		compare_output_pin_first_oe_out == compare_pin_enable_first_in)
		else $error("pin enable not followed");
	chk_irq_gating: assert property (
		timer_irq_out == (((capture_flag_first_out | capture_flag_second_out) & capture_irq_enable_in
			| (compare_flag_first_out | compare_flag_second_out) & compare_irq_enable_in
			| overflow_flag_out & overflow_irq_enable_in) & !cpu_irq_mask_in))
		else $error("interrupt request mismatch");
	chk_wait_wake: assert property (wait_wake_out == timer_irq_out)
		else $error("wake differs from interrupt");
	chk_pwm_no_cmp: assert property (
		pwm_mode_in && $past(pwm_mode_in) && $past(pwm_mode_in, 2) && $past(pwm_mode_in, 3)
			|-> !$rose(compare_flag_first_out) && !$rose(compare_flag_second_out))
		else $error("compare flag set in pwm");
	chk_halt_freeze: assert property (s_halt_held |-> $stable(counter_out))
		else $error("counter moved in halt");
	chk_count_step: assert property (
		!$past(rst_in) && $changed(counter_out) |-> counter_out == CNT_W'($past(counter_out) + 1)
			|| counter_out == 16'hFFFC)
		else $error("counter step wrong");
	chk_wrap_overflow: assert property (
		!$past(rst_in) && $past(counter_out) == 16'hFFFF && counter_out == 16'h0000
			|-> ##[0:2] overflow_flag_out)
		else $error("overflow flag missing");
	chk_reload_capflag: assert property (s_reload |-> ##[0:2] capture_flag_first_out)
		else $error("period end flag missing");
	chk_reset_values: assert property (disable iff (1'b0) rst_in |=> counter_out == 16'hFFFC
		&& compare_value_first_out == 16'h8000 && !compare_output_pin_first_out)
		else $error("reset values wrong");
	chk_equal_levels: assert property (
		pwm_mode_in && match_level_first_in == match_level_second_in
			&& compare_output_pin_first_out == match_level_first_in ##1 pwm_mode_in
			&& $stable({match_level_first_in, match_level_second_in})
			|-> compare_output_pin_first_out == match_level_first_in)
		else $error("pin toggled with equal levels");
endmodule

bind timer_pwm_lowpower_irq timer_pwm_checker #(.CNT_W(CNT_W)) u_chk (.*);

`default_nettype wire

// File: bench/timer_pwm_lowpower_irq_bench.sv
// Self-checking bench for the PWM timer.
// Assumes the checker is bound separately; drives all ports directly.
`default_nettype none

module timer_pwm_lowpower_irq_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_in = 0, rst_in = 1, pwm_mode_in = 0, single_pulse_select_in = 0;
	logic        match_level_first_in = 0, match_level_second_in = 0;
	logic        compare_pin_enable_first_in = 0, capture_edge_first_in = 1;
	logic        capture_edge_second_in = 1, ext_edge_in = 1, capture_irq_enable_in = 0;
	logic        compare_irq_enable_in = 0, overflow_irq_enable_in = 0, cpu_irq_mask_in = 1;
	logic        halt_in = 0, compare_high_byte_wr_in = 0, compare_low_byte_wr_in = 0;
	logic        compare_sel_in = 0, counter_low_byte_acc_in = 0, status_rd_in = 0;
	logic        capture_pin_first_in = 0, capture_pin_second_in = 0, ext_clk_in = 0;
	logic        compare_output_pin_first_out, compare_output_pin_first_oe_out;
	logic        capture_flag_first_out, capture_flag_second_out, compare_flag_first_out;
	logic        compare_flag_second_out, overflow_flag_out, timer_irq_out, wait_wake_out;
	logic [1:0]  clock_select_field_in = 2'h0, compare_low_byte_rd_in = 2'h0;
	logic [1:0]  capture_low_byte_acc_in = 2'h0;
	logic [7:0]  wr_data_in = 8'h00;
	logic [15:0] counter_out, alt_counter_out, compare_value_first_out;
	logic [15:0] compare_value_second_out, capture_value_first_out, capture_value_second_out;
	int          error_cnt = 0;
	int          n_checks = 0;

	timer_pwm_lowpower_irq u_dut (.*);

	initial begin
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic do_reset(input logic [1:0] sel);
		rst_in = 1;
		clock_select_field_in = sel;
		cyc(6);
		rst_in = 0;
	endtask

	task automatic wr_cmp(input logic sel, input logic [15:0] v);
		compare_sel_in = sel;
		compare_high_byte_wr_in = 1;
		wr_data_in = v[15:8];
		cyc(1);
		compare_high_byte_wr_in = 0;
		compare_low_byte_wr_in = 1;
		wr_data_in = v[7:0];
		cyc(1);
		compare_low_byte_wr_in = 0;
	endtask

	task automatic wait_pin(input logic lvl, output int n);
		n = 0;
		while (compare_output_pin_first_out !== lvl && n < 2000) begin
			cyc(1);
			n++;
		end
		if (n >= 2000) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, compare_output_pin_first_out, lvl);
			error_cnt++;
			conclude();
		end
	endtask

	task automatic wait_chg(output int n);
		logic [15:0] v;
		v = counter_out;
		n = 0;
		while (counter_out === v && n < 50) begin
			cyc(1);
			n++;
		end
		if (n >= 50) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, counter_out, v + 16'h0001);
			error_cnt++;
			conclude();
		end
	endtask

	task automatic scen_reset();
		do_reset(2'h0);
		chk(counter_out, 16'hFFFC);
		chk(compare_value_second_out, 16'h8000);
		chk(capture_value_second_out, 16'h0000);
	endtask

	task automatic scen_clk();
		int n;
		int exp[3] = '{4, 2, 8};
		for (int i = 0; i < 3; i++) begin
			clock_select_field_in = 2'(i);
			cyc(10);
			wait_chg(n);
			wait_chg(n);
			chk(16'(n), 16'(exp[i]));
		end
	endtask

	task automatic scen_pwm();
		int n;
		int m;
		do_reset(2'h2);
		{match_level_first_in, match_level_second_in} = 2'b10;
		{compare_pin_enable_first_in, single_pulse_select_in, cpu_irq_mask_in} = 3'b110;
		{capture_irq_enable_in, compare_irq_enable_in, capture_edge_first_in} = 3'b111;
		wr_cmp(0, 16'h0002);
		wr_cmp(1, 16'h0004);
		clock_select_field_in = 2'h1;
		pwm_mode_in = 1;
		wait_pin(1, n);
		wait_pin(0, n);
		chk(16'(n), 16'h0004);
		wait_pin(1, m);
		chk(16'(n + m), 16'h0012);
		chk(capture_flag_first_out, 16'h0001);
		chk(timer_irq_out, 16'h0001);
		chk({compare_flag_first_out, compare_flag_second_out}, 16'h0000);
		wr_cmp(1, 16'h0006);
		chk(compare_value_second_out, 16'h0006);
		wait_pin(0, n);
		chk(16'(n + 2), 16'h0004);
		wait_pin(1, n);
		wait_pin(0, n);
		chk(16'(n), 16'h0008);
		{capture_pin_first_in, capture_pin_second_in} = 2'b11;
		cyc(8);
		chk(capture_flag_second_out, 16'h0001);
		chk(capture_value_first_out, 16'h0000);
		// Pins back to idle so the next reset sees no stale level
		{capture_pin_first_in, capture_pin_second_in} = 2'b00;
	endtask

	task automatic scen_levels();
		int n;
		pwm_mode_in = 0;
		do_reset(2'h1);
		// Short compares so the first match comes well inside the wait bound
		wr_cmp(0, 16'h0002);
		wr_cmp(1, 16'h0004);
		{match_level_first_in, match_level_second_in} = 2'b11;
		pwm_mode_in = 1;
		wait_pin(1, n);
		repeat (40) begin
			cyc(1);
			chk(compare_output_pin_first_out, 16'h0001);
		end
		pwm_mode_in = 0;
	endtask

	task automatic scen_halt_irq();
		logic [15:0] v;
		{compare_pin_enable_first_in, overflow_irq_enable_in, cpu_irq_mask_in} = 3'b011;
		do_reset(2'h1);
		cyc(12);
		chk(compare_output_pin_first_oe_out, 16'h0000);
		chk(overflow_flag_out, 16'h0001);
		chk(timer_irq_out, 16'h0000);
		cpu_irq_mask_in = 0;
		cyc(1);
		chk({timer_irq_out, wait_wake_out}, 16'h0003);
		status_rd_in = 1;
		cyc(1);
		status_rd_in = 0;
		counter_low_byte_acc_in = 1;
		cyc(1);
		counter_low_byte_acc_in = 0;
		cyc(1);
		chk(overflow_flag_out, 16'h0000);
		halt_in = 1;
		cyc(2);
		v = counter_out;
		// Capture edge inside halt only arms the capture
		capture_pin_second_in = 1;
		cyc(20);
		chk(counter_out, v);
		chk(alt_counter_out, v);
		chk(capture_flag_second_out, 16'h0000);
		chk(capture_value_second_out, 16'h0000);
		halt_in = 0;
		cyc(5);
		chk(16'(counter_out > v && counter_out < v + 16'h0004), 16'h0001);
		chk(capture_flag_second_out, 16'h0001);
		chk(capture_value_second_out, v);
		capture_pin_second_in = 0;
	endtask

	initial begin
		scen_reset();
		scen_clk();
		scen_pwm();
		scen_levels();
		scen_halt_irq();
		conclude();
	end
endmodule

`default_nettype wire
